/* rtl/pm_pkg.sv */
// Constants, register map and field layout of the framer performance monitor.
package pm_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned INTERVAL_MS     = 1000;
    localparam int unsigned INTERVAL_CYCLES = INTERVAL_MS * 1000 * CLK_MHZ;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam int          ADDR_W        = 12;
    localparam logic [7:0]  IDX_CFG       = 8'h00;
    localparam logic [7:0]  IDX_E1_GLOBAL = 8'h09;
    localparam logic [7:0]  IDX_T1_GLOBAL = 8'h0c;
    localparam logic [7:0]  IDX_T1_STATUS = 8'h49;
    localparam logic [7:0]  IDX_T1_BEE_LO = 8'h4a;
    localparam logic [7:0]  IDX_T1_BEE_HI = 8'h4b;
    localparam logic [7:0]  IDX_T1_FER_LO = 8'h4c;
    localparam logic [7:0]  IDX_T1_FER_HI = 8'h4d;
    localparam logic [7:0]  IDX_T1_OOF    = 8'h4e;
    localparam logic [7:0]  IDX_T1_ALIGN_CHANGE_COUNT   = 8'h4f;
    localparam logic [7:0]  IDX_E1_STATUS = 8'h68;
    localparam logic [7:0]  IDX_E1_FER    = 8'h69;
    localparam logic [7:0]  IDX_E1_FAR_LO = 8'h6a;
    localparam logic [7:0]  IDX_E1_FAR_HI = 8'h6b;
    localparam logic [7:0]  IDX_E1_CRC_LO = 8'h6c;
    localparam logic [7:0]  IDX_E1_CRC_HI = 8'h6d;
    localparam logic [7:0]  IDX_MODE      = 8'hf0;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int          CFG_AUTO_BIT  = 0;
    localparam int          CFG_NFAS_BIT  = 4;
    localparam int          CFG_WORD_BIT  = 5;
    localparam int          ST_OVR_BIT    = 0;
    localparam int          ST_COUNT_TRANSFER_FLAG_BIT   = 1;
    localparam int          ST_TRANSFER_INTERRUPT_ENABLE_BIT   = 2;
    localparam int          MODE_E1_BIT   = 0;
    localparam int          MODE_ESF_BIT  = 1;
    localparam logic [7:0]  CFG_RST       = 8'h00;
    localparam logic [1:0]  MODE_RST      = 2'h1;
    // Revision code is an arbitrary value.
    localparam logic [7:0]  REVISION_CODE = 8'h5a;

    // ****************************************************************
    // Counter bank
    // ****************************************************************
    localparam int          NCNT          = 5;
    localparam int          CW            = 12;
    localparam int          CNT_ALIGN     = 0;
    localparam int          CNT_FAR       = 1;
    localparam int          CNT_BEE       = 2;
    localparam int          CNT_OOF       = 3;
    localparam int          CNT_ALIGN_CHANGE_COUNT      = 4;
    localparam logic [11:0] LIM_E1_ALIGN  = 12'h07f;
    localparam logic [11:0] LIM_E1_10BIT  = 12'h3ff;
    localparam logic [11:0] LIM_T1_ALIGN  = 12'h1ff;
    localparam logic [11:0] LIM_T1_BEE    = 12'hfff;
    localparam logic [11:0] LIM_T1_OOF    = 12'h01f;
    localparam logic [11:0] LIM_T1_ALIGN_CHANGE_COUNT   = 12'h007;
    localparam logic [11:0] LIM_NONE      = 12'h000;

endpackage : pm_pkg

/* rtl/interval_if.sv */
// Interval tick between the timer and the monitor core.
interface interval_if;
    logic enable;
    logic tick;
    modport timer (input enable, output tick);
    modport user  (output enable, input tick);
endinterface : interval_if

/* rtl/interval_timer.sv */
// Free interval timer giving one tick per interval while enabled.
module interval_timer #(
    parameter int unsigned CYCLES = pm_pkg::INTERVAL_CYCLES
) (
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Tick to the monitor
    interval_if.timer  itf
);
    import pm_pkg::*;

    localparam logic [31:0] LAST = 32'(CYCLES - 1);

    logic [31:0] cnt_q;
    logic        tick_q;

    // Disabling restarts the interval so the first tick is a full one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b0;
        end else if (!itf.enable) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b0;
        end else if (cnt_q >= LAST) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    assign itf.tick = tick_q;

endmodule : interval_timer

/* rtl/perf_monitor.sv */
// Per-framer performance monitor with APB register access.
module perf_monitor #(
    parameter int unsigned INTERVAL_CYCLES = pm_pkg::INTERVAL_CYCLES
) (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [pm_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // E1 events from the frame processor
    input  wire logic                      basic_sync_lost,
    input  wire logic                      crc_mf_sync_lost,
    input  wire logic                      fas_strobe,
    input  wire logic [2:0]                fas_err_bits,
    input  wire logic                      nfas_strobe,
    input  wire logic                      nfas_bit2,
    input  wire logic                      far_end_error,
    input  wire logic                      crc_error,
    // T1/J1 events from the frame processor
    input  wire logic                      t1_align_bit_error,
    input  wire logic                      crc6_error,
    input  wire logic                      out_of_frame,
    input  wire logic                      align_change,
    // Global update shared by the eight framers
    input  wire logic                      global_update_in,
    output logic                           global_update_out,
    // Interrupt
    output logic                           irq
);
    import pm_pkg::*;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic [7:0]    idx;
    logic          setup;
    logic          access;
    logic          wr;
    logic          rd;
    logic          e1;
    logic          esf;
    logic          is_count;
    logic          is_status;
    logic          is_global;
    logic          mapped;
    logic [7:0]    rd_byte;
    logic          pready_q;
    logic          pslverr_q;
    logic [31:0]   prdata_q;
    logic [7:0]    cfg_q;
    logic [1:0]    mode_q;
    logic          transfer_interrupt_enable_q;
    logic          count_transfer_flag_q;
    logic          ovr_q;
    logic          unread_q;
    logic          glb_q;
    logic          irq_q;
    logic          word_pend_q;
    logic          upd;
    logic          glb_wr;
    logic          tick;
    logic [3:0]    inc   [NCNT];
    logic [CW-1:0] lim   [NCNT];
    logic [CW-1:0] run_q [NCNT];
    logic [CW-1:0] run_d [NCNT];
    logic [CW-1:0] lat_q [NCNT];

    interval_if tmr_if ();

    assign idx    = paddr[9:2];
    assign setup  = psel & ~penable;
    assign access = psel & penable & pready_q;
    assign wr     = access & pwrite;
    assign rd     = access & ~pwrite;
    assign e1     = mode_q[MODE_E1_BIT];
    assign esf    = mode_q[MODE_ESF_BIT];

    always_comb begin
        if (e1) begin
            is_count  = (idx >= IDX_E1_FER) && (idx <= IDX_E1_CRC_HI);
            is_status = (idx == IDX_E1_STATUS);
            is_global = (idx == IDX_E1_GLOBAL);
        end else begin
            is_count  = (idx >= IDX_T1_BEE_LO) && (idx <= IDX_T1_ALIGN_CHANGE_COUNT);
            is_status = (idx == IDX_T1_STATUS);
            is_global = (idx == IDX_T1_GLOBAL);
        end
        mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0)
               && (is_count || is_status || is_global
                   || idx == IDX_CFG || idx == IDX_MODE);
    end

    // Read data only depends on the mode's own map.
    always_comb begin
        rd_byte = 8'h00;
        if (e1) begin
            case (idx)
                IDX_E1_FER:    rd_byte = {1'b0, lat_q[CNT_ALIGN][6:0]};
                IDX_E1_FAR_LO: rd_byte = lat_q[CNT_FAR][7:0];
                IDX_E1_FAR_HI: rd_byte = {6'h00, lat_q[CNT_FAR][9:8]};
                IDX_E1_CRC_LO: rd_byte = lat_q[CNT_BEE][7:0];
                IDX_E1_CRC_HI: rd_byte = {6'h00, lat_q[CNT_BEE][9:8]};
                default:       rd_byte = 8'h00;
            endcase
        end else begin
            case (idx)
                IDX_T1_BEE_LO: rd_byte = lat_q[CNT_BEE][7:0];
                IDX_T1_BEE_HI: rd_byte = {4'h0, lat_q[CNT_BEE][11:8]};
                IDX_T1_FER_LO: rd_byte = lat_q[CNT_ALIGN][7:0];
                IDX_T1_FER_HI: rd_byte = {7'h00, lat_q[CNT_ALIGN][8]};
                IDX_T1_OOF:    rd_byte = {3'h0, lat_q[CNT_OOF][4:0]};
                IDX_T1_ALIGN_CHANGE_COUNT:   rd_byte = {5'h00, lat_q[CNT_ALIGN_CHANGE_COUNT][2:0]};
                default:       rd_byte = 8'h00;
            endcase
        end
        if (is_status) begin
            rd_byte = {5'h00, transfer_interrupt_enable_q, count_transfer_flag_q, ovr_q};
        end else if (is_global) begin
            rd_byte = REVISION_CODE;
        end else if (idx == IDX_CFG) begin
            rd_byte = cfg_q;
        end else if (idx == IDX_MODE) begin
            rd_byte = {6'h00, mode_q};
        end
        if (!mapped) begin
            rd_byte = 8'h00;
        end
    end

    // No wait state: the answer is prepared in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup) begin
                prdata_q <= {24'h000000, rd_byte};
            end
        end
    end

    // ****************************************************************
    // Configuration
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q  <= CFG_RST;
            mode_q <= MODE_RST;
        end else if (wr && mapped && idx == IDX_CFG) begin
            cfg_q  <= pwdata[7:0];
        end else if (wr && mapped && idx == IDX_MODE) begin
            mode_q <= pwdata[1:0];
        end
    end

    // ****************************************************************
    // Group update
    // ****************************************************************
    assign tmr_if.enable = cfg_q[CFG_AUTO_BIT];
    assign tick          = tmr_if.tick;
    assign glb_wr        = wr & mapped & is_global;
    assign upd = tick | (wr & mapped & is_count)
               | glb_wr | global_update_in;

    interval_timer #(
        .CYCLES (INTERVAL_CYCLES)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .itf     (tmr_if)
    );

    // The registered pulse tells the seven sibling framers to latch one cycle after this one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glb_q <= 1'b0;
        end else begin
            glb_q <= glb_wr;
        end
    end

    // ****************************************************************
    // Event selection
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_pend_q <= 1'b0;
        end else if (fas_strobe) begin
            word_pend_q <= |fas_err_bits;
        end else if (nfas_strobe) begin
            word_pend_q <= 1'b0;
        end
    end

    always_comb begin
        for (int i = 0; i < NCNT; i++) begin
            inc[i] = 4'h0;
            lim[i] = LIM_NONE;
        end
        if (e1) begin
            lim[CNT_ALIGN] = LIM_E1_ALIGN;
            lim[CNT_FAR]   = LIM_E1_10BIT;
            lim[CNT_BEE]   = LIM_E1_10BIT;
            case ({cfg_q[CFG_WORD_BIT], cfg_q[CFG_NFAS_BIT]})
                2'b00: inc[CNT_ALIGN] = fas_strobe ? {1'b0, fas_err_bits}
                                                   : 4'h0;
                2'b01: inc[CNT_ALIGN] =
                    (fas_strobe ? {1'b0, fas_err_bits} : 4'h0)
                    + {3'h0, nfas_strobe & ~nfas_bit2};
                2'b10: inc[CNT_ALIGN] = {3'h0, fas_strobe & |fas_err_bits};
                // The FAS verdict waits for the following NFAS bit 2.
                2'b11: inc[CNT_ALIGN] =
                    {3'h0, nfas_strobe & (word_pend_q | ~nfas_bit2)};
                default: inc[CNT_ALIGN] = 4'h0;
            endcase
            inc[CNT_FAR] = {3'h0, far_end_error};
            inc[CNT_BEE] = {3'h0, crc_error};
            if (crc_mf_sync_lost) begin
                inc[CNT_FAR] = 4'h0;
                inc[CNT_BEE] = 4'h0;
            end
            if (basic_sync_lost) begin
                inc[CNT_ALIGN] = 4'h0;
                inc[CNT_FAR]   = 4'h0;
                inc[CNT_BEE]   = 4'h0;
            end
        end else begin
            lim[CNT_ALIGN] = LIM_T1_ALIGN;
            lim[CNT_BEE]   = LIM_T1_BEE;
            lim[CNT_OOF]   = LIM_T1_OOF;
            lim[CNT_ALIGN_CHANGE_COUNT]  = LIM_T1_ALIGN_CHANGE_COUNT;
            inc[CNT_ALIGN] = {3'h0, t1_align_bit_error};
            inc[CNT_BEE]   = {3'h0, esf ? crc6_error
                                        : t1_align_bit_error};
            inc[CNT_OOF]   = {3'h0, out_of_frame};
            inc[CNT_ALIGN_CHANGE_COUNT]  = {3'h0, align_change};
        end
    end

    // ****************************************************************
    // Counter bank
    // ****************************************************************
    // Counters saturate rather than wrap, so a long error burst never
    // reads back as a small number.
    for (genvar i = 0; i < NCNT; i++) begin : g_cnt
        logic [CW:0] sum;
        assign sum = {1'b0, run_q[i]} + {9'h000, inc[i]};
        always_comb begin
            if (upd) begin
                run_d[i] = {8'h00, inc[i]};
            end else if (sum > {1'b0, lim[i]}) begin
                run_d[i] = lim[i];
            end else begin
                run_d[i] = sum[CW-1:0];
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                run_q[i] <= '0;
                lat_q[i] <= '0;
            end else begin
                run_q[i] <= run_d[i];
                if (upd) begin
                    lat_q[i] <= run_q[i];
                end
            end
        end
    end

    // ****************************************************************
    // Status and interrupt
    // ****************************************************************
    logic st_wr;
    logic cnt_rd;
    assign st_wr  = wr & mapped & is_status;
    assign cnt_rd = rd & mapped & is_count;

    // A new event in the clearing cycle wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transfer_interrupt_enable_q   <= 1'b0;
            count_transfer_flag_q   <= 1'b0;
            ovr_q    <= 1'b0;
            unread_q <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            if (st_wr) begin
                transfer_interrupt_enable_q <= pwdata[ST_TRANSFER_INTERRUPT_ENABLE_BIT];
            end
            count_transfer_flag_q   <= upd
                      | (count_transfer_flag_q & ~(st_wr & pwdata[ST_COUNT_TRANSFER_FLAG_BIT]));
            ovr_q    <= (upd & unread_q)
                      | (ovr_q & ~(st_wr & pwdata[ST_OVR_BIT]));
            unread_q <= upd | (unread_q & ~cnt_rd);
            irq_q    <= count_transfer_flag_q & transfer_interrupt_enable_q;
        end
    end

    assign prdata            = prdata_q;
    assign pready            = pready_q;
    assign pslverr           = pslverr_q;
    assign global_update_out = glb_q;
    assign irq               = irq_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_word_mode;
        e1 && cfg_q[CFG_WORD_BIT] && !cfg_q[CFG_NFAS_BIT] && !upd
        && !basic_sync_lost && fas_strobe && fas_err_bits != 3'h0
        && run_q[CNT_ALIGN] < LIM_E1_ALIGN
        |=> run_q[CNT_ALIGN] == $past(run_q[CNT_ALIGN]) + 12'h1;
    endproperty
    a_word_mode: assert property (p_word_mode)
        else $error("word mode align count wrong");

    property p_far_end;
        e1 && far_end_error && !basic_sync_lost && !crc_mf_sync_lost
        && !upd && run_q[CNT_FAR] < LIM_E1_10BIT
        |=> run_q[CNT_FAR] == $past(run_q[CNT_FAR]) + 12'h1;
    endproperty
    a_far_end: assert property (p_far_end)
        else $error("far end count did not step");

    property p_sync_gate;
        e1 && basic_sync_lost && !upd
        |=> $stable(run_q[CNT_ALIGN]) && $stable(run_q[CNT_FAR])
            && $stable(run_q[CNT_BEE]);
    endproperty
    a_sync_gate: assert property (p_sync_gate)
        else $error("count moved while sync lost");

    property p_latch;
        upd |=> lat_q[CNT_BEE] == $past(run_q[CNT_BEE])
                && run_q[CNT_BEE] <= 12'h1 && count_transfer_flag_q;
    endproperty
    a_latch: assert property (p_latch)
        else $error("group update not latched");

    property p_auto;
        tick |-> $past(cfg_q[CFG_AUTO_BIT]) ##1 count_transfer_flag_q;
    endproperty
    a_auto: assert property (p_auto)
        else $error("auto tick without enable");

    property p_local;
        wr && mapped && is_count |=> count_transfer_flag_q && unread_q;
    endproperty
    a_local: assert property (p_local)
        else $error("count write did not update");

    property p_global;
        glb_wr |=> global_update_out ##1 !global_update_out;
    endproperty
    a_global: assert property (p_global)
        else $error("global pulse wrong");

    property p_irq;
        count_transfer_flag_q && transfer_interrupt_enable_q |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

    property p_ovr;
        upd && unread_q |=> ovr_q;
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("overwrite flag not set");

    property p_esf_bee;
        !e1 && esf && crc6_error && !upd && run_q[CNT_BEE] < LIM_T1_BEE
        |=> run_q[CNT_BEE] == $past(run_q[CNT_BEE]) + 12'h1;
    endproperty
    a_esf_bee: assert property (p_esf_bee)
        else $error("crc6 count did not step");

    property p_align_change_count_sat;
        !e1 && !$past(e1) |-> run_q[CNT_ALIGN_CHANGE_COUNT] <= LIM_T1_ALIGN_CHANGE_COUNT;
    endproperty
    a_align_change_count_sat: assert property (p_align_change_count_sat)
        else $error("align change count too big");

    c_overwrite: cover property (upd && unread_q);
    c_irq:       cover property (irq);
    c_global:    cover property (glb_wr);

endmodule : perf_monitor

/* bench/frame_events.sv */
// Frame processor model that issues framing and CRC event pulses.
module frame_events (
    // Clock
    input  wire logic       pclk,
    // Sync state
    output logic            basic_sync_lost,
    output logic            crc_mf_sync_lost,
    // Event pulses and qualifiers
    output logic [7:0]      ev,
    output logic [2:0]      fas_err_bits,
    output logic            nfas_bit2
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {basic_sync_lost, crc_mf_sync_lost, ev} = '0;
        {fas_err_bits, nfas_bit2} = 4'h0;
    end
    // Each event is a one-cycle pulse followed by a quiet cycle.
    task automatic pulse(input int k, input int n, input logic [2:0] b);
        repeat (n) begin
            @(posedge pclk);
            ev[k] <= 1'b1;
            fas_err_bits <= b;
            nfas_bit2 <= b[0];
            @(posedge pclk);
            ev <= 8'h00;
            // Qualifiers are not held once the strobe has gone.
            fas_err_bits <= ~b;
            nfas_bit2 <= ~b[0];
        end
    endtask : pulse
    task automatic sync(input logic bl, input logic cl);
        @(posedge pclk);
        basic_sync_lost <= bl;
        crc_mf_sync_lost <= cl;
    endtask : sync
endmodule : frame_events

/* bench/test_framer_performance_monitor.sv */
// Self-checking bench of the performance monitor.
module test_framer_performance_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    import pm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, gu_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, gu_out, irq, bsl, csl, nb2, e;
    logic [7:0] ev, r;
    logic [2:0] feb;
    logic [7:0] align_exp [4] = '{8'h02, 8'h03, 8'h01, 8'h01};
    int errors, n_checks, gu_seen;
    frame_events fu (.pclk(pclk), .basic_sync_lost(bsl),
        .crc_mf_sync_lost(csl), .ev(ev), .fas_err_bits(feb),
        .nfas_bit2(nb2));
    perf_monitor #(.INTERVAL_CYCLES(50)) dut_u (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .basic_sync_lost(bsl), .crc_mf_sync_lost(csl),
        .fas_strobe(ev[0]), .fas_err_bits(feb), .nfas_strobe(ev[1]),
        .nfas_bit2(nb2), .far_end_error(ev[2]), .crc_error(ev[3]),
        .t1_align_bit_error(ev[4]), .crc6_error(ev[5]),
        .out_of_frame(ev[6]), .align_change(ev[7]),
        .global_update_in(gu_in), .global_update_out(gu_out),
        .irq(irq));
    always #5 pclk = ~pclk;
    always @(posedge pclk) if (gu_out === 1'b1) gu_seen++;
    task automatic chk(input string nm, input logic [7:0] x,
                       input logic [7:0] g);
        n_checks++;
        if (g !== x) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    // One APB transfer; the request stands until pready is seen.
    task automatic apb(input logic w, input logic [7:0] i,
                       input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk("pready wait", 8'h01, 8'(n));
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask : wr
    task automatic rd(input logic [7:0] i, input logic [7:0] x);
        apb(1'b0, i, 8'h00);
        chk($sformatf("reg %h", i), x, r);
    endtask : rd
    task automatic bad(input logic [7:0] i);
        apb(1'b0, i, 8'h00);
        chk("slverr", 8'h01, {7'h0, e});
    endtask : bad
    task automatic irq_is(input logic x);
        repeat (2) @(posedge pclk);
        chk("irq", {7'h0, x}, {7'h0, irq});
    endtask : irq_is
    task automatic wrap_up();
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        wrap_up();
    end
    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        {pclk, presetn, psel, penable, pwrite, gu_in} = 6'h0;
        {paddr, pwdata} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(IDX_CFG, CFG_RST);
        rd(IDX_MODE, {6'h0, MODE_RST});
        rd(IDX_E1_GLOBAL, REVISION_CODE);
        fu.pulse(0, 1, 3'h2);
        fu.pulse(2, 3, 3'h0);
        fu.pulse(3, 2, 3'h0);
        fu.sync(1'b1, 1'b0);
        for (int k = 0; k < 4; k++) fu.pulse(k, 1, 3'h2);
        fu.sync(1'b0, 1'b1);
        for (int k = 0; k < 4; k++) fu.pulse(k, 1, 3'h2);
        fu.sync(1'b0, 1'b0);
        wr(IDX_E1_CRC_HI, 8'h00);
        rd(IDX_E1_STATUS, 8'h02);
        rd(IDX_E1_FER, 8'h04);
        rd(IDX_E1_FAR_LO, 8'h03);
        rd(IDX_E1_CRC_LO, 8'h02);
        wr(IDX_E1_STATUS, 8'h03);
        wr(IDX_E1_GLOBAL, 8'h00);
        rd(IDX_E1_STATUS, 8'h02);
        chk("global out", 8'h01, 8'(gu_seen));
        @(posedge pclk);
        gu_in <= 1'b1;
        @(posedge pclk);
        gu_in <= 1'b0;
        rd(IDX_E1_STATUS, 8'h03);
        rd(IDX_E1_FER, 8'h00);
        wr(IDX_E1_STATUS, 8'h04);
        irq_is(1'b1);
        wr(IDX_E1_STATUS, 8'h07);
        irq_is(1'b0);
        rd(IDX_E1_STATUS, 8'h04);
        wr(IDX_E1_STATUS, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(IDX_CFG, 8'(m << 4));
            fu.pulse(0, 1, 3'h2);
            fu.pulse(1, 1, 3'h0);
            wr(IDX_E1_FER, 8'h00);
            rd(IDX_E1_FER, align_exp[m]);
        end
        wr(IDX_E1_STATUS, 8'h03);
        wr(IDX_CFG, 8'h01);
        repeat (60) @(posedge pclk);
        wr(IDX_CFG, 8'h00);
        apb(1'b0, IDX_E1_STATUS, 8'h00);
        chk("auto count_transfer_flag", 8'h02, r & 8'h02);
        bad(8'h30);
        bad(IDX_T1_STATUS);
        wr(IDX_MODE, 8'h00);
        wr(IDX_T1_GLOBAL, 8'h00);
        for (int k = 4; k < 8; k++) fu.pulse(k, 1, 3'h0);
        fu.pulse(4, 1, 3'h0);
        wr(IDX_T1_FER_LO, 8'h00);
        rd(IDX_T1_BEE_LO, 8'h02);
        rd(IDX_T1_FER_LO, 8'h02);
        rd(IDX_T1_OOF, 8'h01);
        rd(IDX_T1_ALIGN_CHANGE_COUNT, 8'h01);
        wr(IDX_MODE, 8'h02);
        for (int k = 4; k < 8; k++) fu.pulse(k, 1, 3'h0);
        fu.pulse(5, 2, 3'h0);
        wr(IDX_T1_GLOBAL, 8'h00);
        rd(IDX_T1_BEE_LO, 8'h03);
        rd(IDX_T1_FER_LO, 8'h01);
        chk("global out", 8'h03, 8'(gu_seen));
        bad(IDX_E1_FER);
        wrap_up();
    end
endmodule : test_framer_performance_monitor
